// File: rtl/shift_exec_defs.svh
`ifndef SHIFT_EXEC_DEFS_SVH
`define SHIFT_EXEC_DEFS_SVH

// ----------------------------------------------------------------
// Opcode patterns (upper bits of the 16-bit instruction)
// ----------------------------------------------------------------
`define OP7_LOAD_UHALF 7'h2d
`define OP7_LOAD_SBYTE 7'h2b
`define OP7_LOAD_SHALF 7'h2f
`define OP5_SHL_IMM 5'h00
`define OP5_SHR_IMM 5'h01
`define OP10_SHL_REG 10'h102
`define OP10_SHR_REG 10'h103
`define SHIFT_TYPE_LSR 2'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLD_OFF_HI 8
`define FLD_OFF_LO 6
`define FLD_BASE_HI 5
`define FLD_BASE_LO 3
`define FLD_TGT_HI 2
`define FLD_TGT_LO 0
`define FLD_AMT_HI 10
`define FLD_AMT_LO 6
`define FLAGS_RESET 4'h0

`endif

// File: rtl/shift_exec_pkg.sv
package shift_exec_pkg;

   typedef enum logic [2:0] {
      OP_NONE, OP_LOAD_UHALF, OP_LOAD_SBYTE, OP_LOAD_SHALF,
      OP_SHL_IMM, OP_SHR_IMM, OP_SHL_REG, OP_SHR_REG
   } op_e;

   // Condition flags, overflow kept for completeness
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } flags_s;

   // Register file write port
   typedef struct packed {
      logic en;
      logic [2:0] idx;
      logic [31:0] data;
   } reg_wr_s;

   // Memory read request
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [1:0] size;
   } mem_req_s;

endpackage

// File: rtl/logical_shifter.sv
`timescale 1ns/1ps
`default_nettype none

// Logical shifter with carry; amount is a full unsigned byte
module logical_shifter (
   // Operand
   input wire logic [31:0] value,
   input wire logic [7:0] amount,
   input wire logic right,
   input wire logic carry_in,
   // Result
   output logic [31:0] result,
   output logic carry_out
);

   // --------------------------------------------------------------
   // Shift
   // --------------------------------------------------------------
   // A 33-bit window holds the last bit shifted out
   wire logic [32:0] left_ext = {1'b0, value};
   wire logic [32:0] right_ext = {value, 1'b0};
   wire logic big = (amount > 8'h20);
   wire logic [5:0] amt6 = amount[5:0];
   wire logic [32:0] left_sh = left_ext << amt6;
   wire logic [32:0] right_sh = right_ext >> amt6;

   // Zero beyond 32, carry held at zero amount
   always_comb begin
      if (amount == 8'h00) begin
         result = value;
         carry_out = carry_in;
      end else if (big) begin
         result = 32'h0;
         carry_out = 1'b0;
      end else if (right) begin
         result = right_sh[32:1];
         carry_out = right_sh[0];
      end else begin
         result = left_sh[31:0];
         carry_out = left_sh[32];
      end
   end

endmodule // logical_shifter

`default_nettype wire

// File: rtl/load_shift_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "shift_exec_defs.svh"

module load_shift_exec (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Instruction issue
   input wire logic issue,
   input wire logic [15:0] instr,
   input wire logic inside_conditional_block,
   // Register file read data, indexed by read ports a and b
   output logic [2:0] rd_a_idx,
   output logic [2:0] rd_b_idx,
   input wire logic [31:0] rd_a_data,
   input wire logic [31:0] rd_b_data,
   // Memory system
   output shift_exec_pkg::mem_req_s mem_req,
   input wire logic mem_rvalid,
   input wire logic [31:0] mem_rdata,
   // Results
   output shift_exec_pkg::reg_wr_s reg_wr,
   output shift_exec_pkg::flags_s program_flags_word,
   output logic busy,
   output logic illegal
);

   typedef enum {ST_IDLE, ST_WAIT} state_e;

   // --------------------------------------------------------------
   // Decode
   // --------------------------------------------------------------
   wire logic [2:0] fld_off = instr[`FLD_OFF_HI:`FLD_OFF_LO];
   wire logic [2:0] fld_base = instr[`FLD_BASE_HI:`FLD_BASE_LO];
   wire logic [2:0] fld_tgt = instr[`FLD_TGT_HI:`FLD_TGT_LO];
   wire logic [4:0] shift_amount_field = instr[`FLD_AMT_HI:`FLD_AMT_LO];
   wire logic is_uhalf = (instr[15:9] == `OP7_LOAD_UHALF);
   wire logic is_sbyte = (instr[15:9] == `OP7_LOAD_SBYTE);
   wire logic is_shalf = (instr[15:9] == `OP7_LOAD_SHALF);
   wire logic is_shl_imm = (instr[15:11] == `OP5_SHL_IMM);
   wire logic is_shr_imm = (instr[15:11] == `OP5_SHR_IMM);
   wire logic is_shl_reg = (instr[15:6] == `OP10_SHL_REG);
   wire logic is_shr_reg = (instr[15:6] == `OP10_SHR_REG);
   wire logic is_move = is_shl_imm && (shift_amount_field == 5'h00);
   wire logic is_load = is_uhalf || is_sbyte || is_shalf;
   wire logic is_reg_shift = is_shl_reg || is_shr_reg;
   wire logic is_shift = is_shl_imm || is_shr_imm || is_reg_shift;

   // Read ports: loads read base and offset; register shifts read operand and amount
   // Register shifts name one field for operand and result
   assign rd_a_idx = is_load ? fld_base : (is_reg_shift ? fld_tgt : fld_base);
   // Register shifts take their amount register from bits 5..3, not 8..6
   assign rd_b_idx = is_reg_shift ? fld_base : fld_off;

   // --------------------------------------------------------------
   // Shift amount and operand
   // --------------------------------------------------------------
   // Immediate right shift field of zero encodes 32
   wire logic [7:0] imm_rshift = (shift_amount_field == 5'h00) ? 8'h20
                                 : {3'h0, shift_amount_field};
   wire logic [7:0] shift_amt = is_reg_shift ? rd_b_data[7:0]
                                : (is_shr_imm ? imm_rshift
                                : {3'h0, shift_amount_field});
   wire logic shift_right = is_shr_imm || is_shr_reg;
   // Immediate forms shift the source in bits 5..3, register forms the Rdn
   wire logic [31:0] shift_src = rd_a_data;
   wire logic [31:0] sh_result;
   wire logic sh_carry;

   logical_shifter u_shifter (
      .value(shift_src),
      .amount(shift_amt),
      .right(shift_right),
      .carry_in(program_flags_word.c),
      .result(sh_result),
      .carry_out(sh_carry)
   );

   // --------------------------------------------------------------
   // Load address and extension
   // --------------------------------------------------------------
   // Offset mode only: the base register is never a write target
   wire logic [31:0] load_addr = rd_a_data + rd_b_data;
   wire logic [1:0] load_size = is_sbyte ? 2'h0 : 2'h1;

   state_e state_reg, state_next;
   shift_exec_pkg::op_e op_reg;
   logic [2:0] tgt_reg;

   wire logic [31:0] ext_uhalf = {16'h0, mem_rdata[15:0]};
   wire logic [31:0] ext_sbyte = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
   wire logic [31:0] ext_shalf = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
   wire logic [31:0] load_data = (op_reg == shift_exec_pkg::OP_LOAD_SBYTE) ? ext_sbyte
                                 : (op_reg == shift_exec_pkg::OP_LOAD_SHALF) ? ext_shalf
                                 : ext_uhalf;

   wire logic accept = issue && (state_reg == ST_IDLE);
   wire logic load_done = (state_reg == ST_WAIT) && mem_rvalid;

   // --------------------------------------------------------------
   // Flags
   // --------------------------------------------------------------
   // Shifts set flags only outside a conditional block; move keeps C
   wire logic set_flags = accept && is_shift && !inside_conditional_block;
   shift_exec_pkg::flags_s flags_next;
   always_comb begin
      flags_next = program_flags_word;
      if (set_flags) begin
         flags_next.n = sh_result[31];
         flags_next.z = (sh_result == 32'h0);
         flags_next.c = is_move ? program_flags_word.c : sh_carry;
      end
   end

   // Next state
   always_comb begin
      state_next = state_reg;
      if (accept && is_load) state_next = ST_WAIT;
      else if (load_done) state_next = ST_IDLE;
   end

   // Result write target: immediate forms to bits 2..0, register forms to Rdn
   wire logic [2:0] wr_idx = accept ? fld_tgt : tgt_reg;
   wire logic wr_en = (accept && is_shift) || load_done;
   wire logic [31:0] wr_data = load_done ? load_data : sh_result;

   // --------------------------------------------------------------
   // State and outputs
   // --------------------------------------------------------------
   // Only one load outstanding; issue while busy is dropped
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         op_reg <= shift_exec_pkg::OP_NONE;
         tgt_reg <= 3'h0;
         program_flags_word <= `FLAGS_RESET;
         reg_wr <= '0;
         mem_req <= '0;
         busy <= 1'b0;
         illegal <= 1'b0;
      end else begin
         state_reg <= state_next;
         program_flags_word <= flags_next;
         reg_wr <= {wr_en, wr_idx, wr_data};
         busy <= (state_next == ST_WAIT);
         illegal <= accept && !is_load && !is_shift;
         mem_req <= {accept && is_load, load_addr, load_size};
         if (accept && is_load) begin
            tgt_reg <= fld_tgt;
            op_reg <= is_sbyte ? shift_exec_pkg::OP_LOAD_SBYTE
                      : (is_shalf ? shift_exec_pkg::OP_LOAD_SHALF
                      : shift_exec_pkg::OP_LOAD_UHALF);
         end
      end
   end

endmodule // load_shift_exec

`default_nettype wire

// File: sim/load_shift_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the load and shift unit
// ----------------------------------------
module load_shift_exec_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Issue and register reads
   input wire logic issue,
   input wire logic [15:0] instr,
   input wire logic inside_conditional_block,
   input wire logic [2:0] rd_a_idx,
   input wire logic [2:0] rd_b_idx,
   input wire logic [31:0] rd_a_data,
   input wire logic [31:0] rd_b_data,
   // Memory and results
   input wire shift_exec_pkg::mem_req_s mem_req,
   input wire logic mem_rvalid,
   input wire shift_exec_pkg::reg_wr_s reg_wr,
   input wire shift_exec_pkg::flags_s program_flags_word,
   input wire logic busy
);
   logic [2:0] tgt_reg;
   // Accepted requests by kind
   wire take = issue && !busy;
   // Only the three register-offset loads; other words in this group are illegal
   wire ld = take && (instr[15:9] == 7'h2d || instr[15:9] == 7'h2b || instr[15:9] == 7'h2f);
   wire shl_i = take && instr[15:11] == 5'h00;
   wire shr_r = take && instr[15:6] == 10'h103;
   wire sh = take && (instr[15:12] == 4'h0 || instr[15:7] == 9'h081);
   // Target kept, since memory answers late
   always_ff @(posedge mclk) if (ld) tgt_reg <= instr[2:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_LOAD_ADDR:
      assert property (ld |=> mem_req.valid && mem_req.addr == $past(rd_a_data) + $past(rd_b_data))
      else $error("load address wrong");
   AST_LOAD_SIZE:
      assert property (ld |=> mem_req.size == {1'b0, $past(instr[11])})
      else $error("load size wrong");
   AST_LOAD_FIELDS:
      assert property (ld |-> rd_a_idx == instr[5:3] && rd_b_idx == instr[8:6])
      else $error("load fields wrong");
   AST_RSHIFT_FIELDS:
      assert property (take && instr[15:7] == 9'h081
         |-> rd_a_idx == instr[2:0] && rd_b_idx == instr[5:3])
      else $error("register shift fields wrong");
   AST_LOAD_WRITE:
      assert property (busy && mem_rvalid |=> reg_wr.en && reg_wr.idx == tgt_reg)
      else $error("load write wrong");
   AST_SHL_IMM:
      assert property (shl_i |=> reg_wr.en && reg_wr.data == $past(rd_a_data) << $past(instr[10:6]))
      else $error("left shift wrong");
   AST_SHR_REG:
      assert property (shr_r |=> reg_wr.data == $past(rd_a_data) >> $past(rd_b_data[7:0]))
      else $error("right shift wrong");
   AST_FLAG_HOLD:
      assert property (take && inside_conditional_block |=> $stable(program_flags_word))
      else $error("flags moved");
   AST_FLAG_NZ:
      assert property (sh && !inside_conditional_block |=> program_flags_word.n == reg_wr.data[31]
         && program_flags_word.z == (reg_wr.data == 32'h0) && $stable(program_flags_word.v))
      else $error("flags wrong");
   COV_SLOW: cover property (busy [*3]);
   COV_COND: cover property (take && inside_conditional_block);
   COV_BIG: cover property (shr_r && rd_b_data[7:0] >= 8'h20);
endmodule // load_shift_exec_checker
bind load_shift_exec load_shift_exec_checker i_chk (.mclk, .rst_b, .issue, .instr,
   .inside_conditional_block, .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data, .mem_req,
   .mem_rvalid, .reg_wr, .program_flags_word, .busy);
`default_nettype wire

// File: sim/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Memory responder with chosen latency
// ----------------------------------------
module mem_model (
   // Clock and request
   input wire logic mclk,
   input wire shift_exec_pkg::mem_req_s mem_req,
   // Bench control
   input wire logic [3:0] lat,
   input wire logic [31:0] word,
   // Response
   output logic mem_rvalid,
   output logic [31:0] mem_rdata
);
   logic [3:0] cnt_reg = 4'h0;
   logic live_reg = 1'b0;
   // Count down, then one pulse
   always @(posedge mclk) begin
      if (mem_req.valid)
         cnt_reg <= lat;
      else if (live_reg)
         cnt_reg <= cnt_reg - 4'h1;
      if (mem_req.valid)
         live_reg <= 1'b1;
      else if (mem_rvalid)
         live_reg <= 1'b0;
   end
   assign mem_rvalid = live_reg && cnt_reg == 4'h0;
   // Idle bus inverted so stale data never matches
   assign mem_rdata = mem_rvalid ? word : ~word;
endmodule // mem_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench;
   typedef struct packed {logic [15:0] i; logic [31:0] a, b, m, d; logic [2:0] f;} row_s;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic issue = 1'b0;
   logic inside_conditional_block = 1'b0;
   logic [15:0] instr = 16'h0;
   logic [31:0] rd_a_data = 32'h0;
   logic [31:0] rd_b_data = 32'h0;
   logic [31:0] word = 32'h0;
   logic [3:0] lat = 4'h0;
   logic mem_rvalid, busy, got, illegal;
   logic [31:0] mem_rdata;
   shift_exec_pkg::mem_req_s mem_req;
   shift_exec_pkg::reg_wr_s reg_wr;
   shift_exec_pkg::flags_s program_flags_word;
   int errors = 0;
   int check_count = 0;
   row_s rows [12];
   load_shift_exec i_dut (.mclk, .rst_b, .issue, .instr, .inside_conditional_block,
      .rd_a_idx(), .rd_b_idx(), .rd_a_data, .rd_b_data, .mem_req, .mem_rvalid,
      .mem_rdata, .reg_wr, .program_flags_word, .busy, .illegal);
   mem_model i_mem (.mclk, .mem_req, .lat, .word, .mem_rvalid, .mem_rdata);
   // 10 MHz clock
   initial begin
      forever #50 mclk = ~mclk;
   end
   task report_and_stop();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One instruction; sp keeps issue up into the busy window
   task run(input logic [15:0] i, input logic [31:0] a, b, m, input logic c, sp);
      @(posedge mclk);
      issue <= 1'b1;
      instr <= i;
      rd_a_data <= a;
      rd_b_data <= b;
      word <= m;
      inside_conditional_block <= c;
      @(posedge mclk);
      issue <= sp;
      instr <= 16'h004a;
      got = 1'b0;
      for (int n = 0; n < 20 && !got; n++) begin
         #1;
         if (mem_req.valid === 1'b1) chk(mem_req.addr, a + b);
         if (reg_wr.en === 1'b1) got = 1'b1;
         else begin
            @(posedge mclk);
            issue <= 1'b0;
         end
      end
      if (!got) begin
         errors++;
         report_and_stop();
      end
      chk(32'(reg_wr.idx), 32'(i[2:0]));
   endtask
   initial begin
      rows = '{'{16'h5a55, 32'h1000, 32'h2, 32'h8123, 32'h8123, 3'h0},
         '{16'h56c1, 32'h2000, 32'h5, 32'h12345680, 32'hffffff80, 3'h0},
         '{16'h5ff7, 32'hfffffffe, 32'h4, 32'hdead7fff, 32'h7fff, 3'h0},
         '{16'h004a, 32'h80000001, 32'h0, 32'h0, 32'h2, 3'h1},
         '{16'h001c, 32'h80000000, 32'h0, 32'h0, 32'h80000000, 3'h5},
         '{16'h0806, 32'h1, 32'h0, 32'h0, 32'h0, 3'h2},
         '{16'h0913, 32'hf0000018, 32'h0, 32'h0, 32'h0f000001, 3'h1},
         '{16'h4095, 32'h3, 32'hffffff21, 32'h0, 32'h0, 3'h2},
         '{16'h40d8, 32'h80000000, 32'h120, 32'h0, 32'h0, 3'h3},
         '{16'h4091, 32'h5, 32'hffffff00, 32'h0, 32'h5, 3'h1},
         '{16'h40df, 32'h2, 32'h1, 32'h0, 32'h1, 3'h0},
         '{16'h07c8, 32'h3, 32'h0, 32'h0, 32'h80000000, 3'h5}};
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      for (int k = 0; k < 12; k++) begin
         run(rows[k].i, rows[k].a, rows[k].b, rows[k].m, 1'b0, 1'b0);
         chk(reg_wr.data, rows[k].d);
         chk(32'(program_flags_word), 32'({rows[k].f, 1'b0}));
      end
      // Flags frozen inside a conditional block
      run(16'h0913, 32'hf0000018, 32'h0, 32'h0, 1'b1, 1'b0);
      chk(reg_wr.data, 32'h0f000001);
      chk(32'(program_flags_word), 32'ha);
      // Slow memory, issue refused while busy
      lat <= 4'h3;
      run(16'h56c1, 32'h2000, 32'h5, 32'h12345680, 1'b0, 1'b1);
      chk(reg_wr.data, 32'hffffff80);
      @(posedge mclk);
      #1;
      chk(32'(reg_wr.en), 32'h0);
      // Unsupported word is flagged and writes nothing
      @(posedge mclk);
      issue <= 1'b1;
      instr <= 16'hffff;
      @(posedge mclk);
      issue <= 1'b0;
      #1;
      chk(32'({illegal, reg_wr.en}), 32'h2);
      // Reset in mid-run clears flags
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      chk(32'(program_flags_word), 32'h0);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
